// ---- rtl/gpio_sleep_defines.vh ----
// gpio_sleep_defines.vh: offsets, field positions and reset values for the
// gpio pending-status and hibernate pin-hold block.
// assumes wishbone word addressing; included by bare name.
`ifndef GPIO_SLEEP_DEFINES_VH
`define GPIO_SLEEP_DEFINES_VH

// printed offsets are not all multiples of four: these are indices
`define IDX_IRQ_PENDING_STATUS 32'h0B000314
`define IDX_HIB_STATE_UPPER 32'h0B000316
`define IDX_HIB_STATE_LOWER 32'h0B000318
// local registers: indices chosen past the printed ones
`define IDX_IRQ_MASK 32'h0B000320
`define IDX_TRIG_TYPE_LO 32'h0B000321
`define IDX_TRIG_TYPE_HI 32'h0B000322
`define IDX_PIN_IS_INPUT 32'h0B000323
`define IDX_HIB_CTRL 32'h0B000324
`define IDX_PIN_LEVEL 32'h0B000325

`define REG_ADDR_W 30
`define RST_PENDING 16'h0000
`define RST_HIB_STATE 16'h0000
`define RST_MASK 16'h0000
`define RST_TRIG 32'h00000000
`define RST_INPUT 32'h00000000
`define HIB_CTRL_ACTIVE_BIT 0

`define TRIG_FALL 2'h0
`define TRIG_RISE 2'h1
`define TRIG_LOW 2'h2
`define TRIG_HIGH 2'h3

`endif

// ---- rtl/gpio_sleep_hold.v ----
// gpio_sleep_hold.v: gpio pending-status register and hibernate pin hold.
// assumes a classic wishbone master; pins are asynchronous to clk.
// How it works
// RQ1: one pending bit per pin 0..15
// RQ2: pending tracks only general-purpose input pins
// RQ3: pending reads regardless of interrupt mask
// RQ4: edge type: writing one clears latched request
// RQ5: rtc-domain reset zeroes; other resets keep values
// RQ6: keep bit 0: output released, input ignored
// RQ7: keep bit 1: output driven, input monitored
// RQ8: upper register bit n controls pin n+16
// RQ9: lower register bit n controls pin n
// RQ10: software sets keep bit for wake-up pins
// RQ11: software clears keep bits of inputs, except 29
// RQ12: trigger type: fall, rise, low, high
// RQ13: level type: pending follows active pin level
// RQ14: writing zero leaves pending bit unchanged
//
// Register access over Wishbone was decided locally.
`default_nettype none
`include "gpio_sleep_defines.vh"

module gpio_sleep_hold (
  input wire clk, // 250 MHz system clock
  input wire rst_b, // system reset, async, active low
  input wire rtc_domain_reset_b, // rtc-domain reset, async, active low
  input wire wb_cyc_i, // wishbone cycle
  input wire wb_stb_i, // wishbone strobe
  input wire wb_we_i, // wishbone write enable
  input wire [31:2] wb_adr_i, // wishbone word address
  input wire [3:0] wb_sel_i, // wishbone byte selects
  input wire [31:0] wb_dat_i, // wishbone write data
  output reg [31:0] wb_dat_o, // wishbone read data
  output reg wb_ack_o, // wishbone acknowledge
  output reg wb_err_o, // wishbone error on unmapped address
  input wire [31:0] gpio_in, // pin input levels
  input wire [31:0] core_out, // output values from the port logic
  input wire [31:0] core_oe_b, // output enables from port logic, low drives
  output reg [31:0] gpio_out, // pin output values
  output reg [31:0] gpio_oe_b, // pin output enables, low drives
  output reg [31:0] gpio_in_seen, // pin levels seen by the core
  output reg [15:0] wake_event, // wake-up levels while hibernating
  output reg irq // level interrupt, unmasked pending
);
  reg [31:0] meta_reg;
  reg [31:0] sync_reg;
  reg [31:0] prev_reg;
  reg [15:0] hib_upper_reg;
  reg [15:0] hib_lower_reg;
  reg [15:0] mask_reg;
  reg [31:0] trig_reg;
  reg [31:0] input_reg;
  reg hib_reg;
  reg [15:0] clear_reg;
  wire [15:0] irq_pending_bit;
  wire [31:0] sleep_pin_keep_bit;
  wire req;
  wire [31:0] idx;
  reg hit_any;
  reg [31:0] rdata;

  assign req = wb_cyc_i & wb_stb_i & ~wb_ack_o & ~wb_err_o;
  assign idx = {2'b00, wb_adr_i};
  assign sleep_pin_keep_bit = {hib_upper_reg, hib_lower_reg}; // RQ8 RQ9

  // byte-lane merge for the keep-state, mask, trigger and input registers
  function [31:0] merge;
    input [31:0] old;
    input [31:0] din;
    input [3:0] sel;
    integer i;
    begin
      merge = old;
      for (i = 0; i < 4; i = i + 1) begin
        if (sel[i]) begin
          merge[i*8 +: 8] = din[i*8 +: 8];
        end
      end
    end
  endfunction

  // 16-bit registers and trigger halves keep the low half of a merged word
  function [15:0] lo16;
    input [31:0] v;
    begin
      lo16 = v[15:0];
    end
  endfunction

  // pins are asynchronous: two stages before anything reads them
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      meta_reg <= 32'h00000000;
      sync_reg <= 32'h00000000;
      prev_reg <= 32'h00000000;
    end else begin
      meta_reg <= gpio_in;
      sync_reg <= meta_reg;
      prev_reg <= sync_reg;
    end
  end

  genvar g;
  generate
    for (g = 0; g < 16; g = g + 1) begin : pin
      pin_event_detect det (
        .clk(clk),
        .rtc_domain_reset_b(rtc_domain_reset_b),
        .level_sync(sync_reg[g]),
        .level_prev(prev_reg[g]),
        .enable(input_reg[g]),
        .pin_trigger_type(trig_reg[2*g +: 2]),
        .clear_wr(clear_reg[g]),
        .irq_pending_bit(irq_pending_bit[g])
      ); // RQ1
    end
  endgenerate

  always @* begin
    hit_any = 1'b1;
    rdata = 32'h00000000;
    case (idx)
      `IDX_IRQ_PENDING_STATUS: rdata = {16'h0000, irq_pending_bit}; // RQ3
      `IDX_HIB_STATE_UPPER: rdata = {16'h0000, hib_upper_reg};
      `IDX_HIB_STATE_LOWER: rdata = {16'h0000, hib_lower_reg};
      `IDX_IRQ_MASK: rdata = {16'h0000, mask_reg};
      `IDX_TRIG_TYPE_LO: rdata = {16'h0000, trig_reg[15:0]};
      `IDX_TRIG_TYPE_HI: rdata = {16'h0000, trig_reg[31:16]};
      `IDX_PIN_IS_INPUT: rdata = input_reg;
      `IDX_HIB_CTRL: rdata = {31'h00000000, hib_reg};
      `IDX_PIN_LEVEL: rdata = sync_reg;
      default: hit_any = 1'b0;
    endcase
  end

  // keep-state registers belong to the rtc domain and survive rst_b
  always @(posedge clk or negedge rtc_domain_reset_b) begin
    if (!rtc_domain_reset_b) begin
      hib_upper_reg <= `RST_HIB_STATE; // RQ5
      hib_lower_reg <= `RST_HIB_STATE; // RQ5
      mask_reg <= `RST_MASK;
      trig_reg <= `RST_TRIG;
      input_reg <= `RST_INPUT;
    end else if (req && wb_we_i) begin
      case (idx)
        `IDX_HIB_STATE_UPPER:
          hib_upper_reg <= lo16(merge({16'h0000, hib_upper_reg}, wb_dat_i,
            wb_sel_i)); // RQ8
        `IDX_HIB_STATE_LOWER:
          hib_lower_reg <= lo16(merge({16'h0000, hib_lower_reg}, wb_dat_i,
            wb_sel_i)); // RQ9
        `IDX_IRQ_MASK:
          mask_reg <= lo16(merge({16'h0000, mask_reg}, wb_dat_i,
            wb_sel_i));
        `IDX_TRIG_TYPE_LO:
          trig_reg[15:0] <= lo16(merge({16'h0000, trig_reg[15:0]},
            wb_dat_i, wb_sel_i)); // RQ12
        `IDX_TRIG_TYPE_HI:
          trig_reg[31:16] <= lo16(merge({16'h0000, trig_reg[31:16]},
            wb_dat_i, wb_sel_i)); // RQ12
        `IDX_PIN_IS_INPUT:
          input_reg <= merge(input_reg, wb_dat_i, wb_sel_i);
        default: ;
      endcase
    end
  end

  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      wb_ack_o <= 1'b0;
      wb_err_o <= 1'b0;
      wb_dat_o <= 32'h00000000;
      clear_reg <= 16'h0000;
      hib_reg <= 1'b0;
      irq <= 1'b0;
    end else begin
      wb_ack_o <= req & hit_any;
      wb_err_o <= req & ~hit_any;
      wb_dat_o <= (req & hit_any & ~wb_we_i) ? rdata : 32'h00000000;
      clear_reg <= 16'h0000;
      if (req && wb_we_i && idx == `IDX_IRQ_PENDING_STATUS) begin
        // zeros written leave bits alone
        clear_reg <= {wb_sel_i[1] ? wb_dat_i[15:8] : 8'h00,
          wb_sel_i[0] ? wb_dat_i[7:0] : 8'h00}; // RQ4 RQ14
      end
      if (req && wb_we_i && idx == `IDX_HIB_CTRL && wb_sel_i[0]) begin
        hib_reg <= wb_dat_i[`HIB_CTRL_ACTIVE_BIT];
      end
      irq <= |(irq_pending_bit & mask_reg);
    end
  end

  // pin hold: outside hibernate the port logic passes straight through
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      gpio_out <= 32'h00000000;
      gpio_oe_b <= 32'hFFFFFFFF;
      gpio_in_seen <= 32'h00000000;
      wake_event <= 16'h0000;
    end else begin
      gpio_out <= core_out;
      gpio_oe_b <= hib_reg ? (core_oe_b | ~sleep_pin_keep_bit)
        : core_oe_b; // RQ6 RQ7
      gpio_in_seen <= hib_reg ? (sync_reg & sleep_pin_keep_bit)
        : sync_reg; // RQ6 RQ7
      // wake-up only from pins software left monitored
      wake_event <= hib_reg ? (sync_reg[15:0] & hib_lower_reg)
        : 16'h0000; // RQ10
    end
  end
endmodule
`default_nettype wire

// ---- rtl/pin_event_detect.v ----
// pin_event_detect.v: one pin's trigger detection and pending flag.
// assumes a synchronised pin level and a software clear pulse.
`default_nettype none
`include "gpio_sleep_defines.vh"

module pin_event_detect (
  input wire clk, // system clock
  input wire rtc_domain_reset_b, // rtc-domain reset, async, active low
  input wire level_sync, // synchronised pin level
  input wire level_prev, // level one cycle earlier
  input wire enable, // pin is a general-purpose input
  input wire [1:0] pin_trigger_type, // trigger selection
  input wire clear_wr, // software wrote one to this bit
  output reg irq_pending_bit // latched or level pending state
);
  reg is_edge;
  reg hit;

  always @* begin
    is_edge = ~pin_trigger_type[1]; // RQ12
    case (pin_trigger_type)
      `TRIG_FALL: hit = level_prev & ~level_sync;
      `TRIG_RISE: hit = ~level_prev & level_sync;
      `TRIG_LOW: hit = ~level_sync;
      `TRIG_HIGH: hit = level_sync;
      default: hit = 1'b0;
    endcase
  end

  // only the rtc-domain reset touches the flag; other resets keep it
  always @(posedge clk or negedge rtc_domain_reset_b) begin
    if (!rtc_domain_reset_b) begin
      irq_pending_bit <= 1'b0; // RQ5
    end else if (!enable) begin
      irq_pending_bit <= 1'b0; // RQ2
    end else if (!is_edge) begin
      irq_pending_bit <= hit; // RQ13
    end else if (hit) begin
      irq_pending_bit <= 1'b1; // set wins over a same-cycle clear
    end else if (clear_wr) begin
      irq_pending_bit <= 1'b0; // RQ4
    end
  end
endmodule
`default_nettype wire

// ---- test/gpio_sleep_hold_assertions.sv ----
// checker: bus answers, read data and pin states in reset
// bound to gpio_sleep_hold from the bench top file
`default_nettype none
`include "gpio_sleep_defines.vh"
module gpio_sleep_hold_assertions (
  input wire clk, // clock
  input wire rst_b, // system reset
  input wire rtc_domain_reset_b, // rtc reset
  input wire wb_cyc_i, // cycle
  input wire wb_stb_i, // strobe
  input wire [31:2] wb_adr_i, // word address
  input wire [31:0] wb_dat_o, // read data
  input wire wb_ack_o, // ack
  input wire wb_err_o, // error
  input wire [31:0] core_out, // port value
  input wire [31:0] gpio_out, // pin value
  input wire [31:0] gpio_oe_b, // pin enable
  input wire irq // interrupt
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);
  sequence s_req;
    wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_err_o;
  endsequence
  sequence s_ans;
    (wb_ack_o ^ wb_err_o) ##1 !(wb_ack_o || wb_err_o);
  endsequence
  a_req_answer: assert property (s_req |=> s_ans)
    else $error("request not answered once");
  a_ack_cause: assert property (wb_ack_o || wb_err_o |->
    $past(wb_cyc_i && wb_stb_i)) else $error("answer without request");
  a_ack_err_excl: assert property (!(wb_ack_o && wb_err_o))
    else $error("ack and err together");
  a_dat_idle: assert property (!wb_ack_o |-> wb_dat_o == 32'h0)
    else $error("read data outside ack");
  // pin-level and input-config words are 32 bits wide by choice
  a_dat_upper: assert property (wb_ack_o
    && $past({2'b00, wb_adr_i}) != `IDX_PIN_IS_INPUT
    && $past({2'b00, wb_adr_i}) != `IDX_PIN_LEVEL
    |-> wb_dat_o[31:16] == 16'h0) else $error("upper read bits set");
  a_out_delay: assert property (1 |=> gpio_out == $past(core_out))
    else $error("pin output lags wrongly");
  a_oe_reset: assert property (disable iff (!rtc_domain_reset_b)
    !rst_b |-> gpio_oe_b == 32'hFFFFFFFF) else $error("pins driven in reset");
  a_irq_reset: assert property (disable iff (!rtc_domain_reset_b)
    !rst_b |-> !irq && gpio_out == 32'h0) else $error("outputs live in reset");
endmodule
`default_nettype wire

// ---- test/gpio_sleep_hold_bench.sv ----
// bench for gpio_sleep_hold: wishbone tasks, pin stimulus, queued reads
// assumes pin_world and the checker; one 250 MHz clock
`default_nettype none
`include "gpio_sleep_defines.vh"
module gpio_sleep_hold_bench;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [31:0] PND = `IDX_IRQ_PENDING_STATUS;
  localparam logic [31:0] UP = `IDX_HIB_STATE_UPPER;
  localparam logic [31:0] LO = `IDX_HIB_STATE_LOWER;
  logic clk = 0, rst_b = 0, rtc_domain_reset_b = 0;
  logic wb_cyc_i = 0, wb_stb_i = 0, wb_we_i = 0;
  logic [31:2] wb_adr_i = 30'h0;
  logic [3:0] wb_sel_i = 4'hF;
  logic [31:0] wb_dat_i = 32'h0, core_out = 32'h0, ext = 32'h0;
  logic [31:0] core_oe_b = 32'hFFFFFFFF, r, x;
  logic [31:0] wb_dat_o, gpio_out, gpio_oe_b, gpio_in_seen, pins;
  logic [15:0] wake_event;
  logic wb_ack_o, wb_err_o, irq;
  logic [33:0] q[$];
  logic [33:0] nt;
  int seed = 32'h3E4A81D5;
  int errors = 0, checks = 0;
  gpio_sleep_hold u_gpio_sleep_hold (.clk, .rst_b, .rtc_domain_reset_b,
    .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i,
    .wb_dat_o, .wb_ack_o, .wb_err_o, .gpio_in(pins), .core_out,
    .core_oe_b, .gpio_out, .gpio_oe_b, .gpio_in_seen, .wake_event, .irq);
  pin_world u_pin_world (.ext_level(ext), .gpio_out, .gpio_oe_b,
    .pin_level(pins));
  initial forever #2 clk = ~clk;
  task check(input logic [31:0] s, e);
    checks++;
    if (s !== e) begin
      errors++;
      $display("ERROR %0t: saw %h want %h", $time, s, e);
    end
  endtask
  task stop_test;
    $display("errors=%0d checks=%0d", errors, checks);
    if (errors == 0 && checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  // note: {compare data, expect err, data}
  task wb(input logic we, input logic [31:0] a, d, input logic [33:0] n);
    q.push_back(n);
    wb_cyc_i <= 1;
    wb_stb_i <= 1;
    wb_we_i <= we;
    wb_adr_i <= a[29:0];
    wb_dat_i <= d;
    do @(posedge clk); while (!(wb_ack_o | wb_err_o));
    wb_cyc_i <= 0;
    wb_stb_i <= 0;
    @(posedge clk);
  endtask
  task wr(input logic [31:0] a, d);
    wb(1, a, d, {2'b00, 32'h0});
  endtask
  task rd(input logic [31:0] a, e);
    wb(0, a, 32'h0, {2'b10, e});
  endtask
  always @(posedge clk) if (wb_ack_o | wb_err_o) begin
    nt = q.pop_front();
    check({31'h0, wb_err_o}, {31'h0, nt[32]});
    if (nt[33]) check(wb_dat_o, nt[31:0]);
  end
  initial begin
    #100000;
    errors++;
    stop_test;
  end
  initial begin
    repeat (12) @(posedge clk);
    rst_b <= 1;
    rtc_domain_reset_b <= 1;
    @(posedge clk);
    rd(PND, 0);
    rd(UP, 0);
    rd(LO, 0);
    wb(0, 32'h0B000330, 32'h0, {2'b01, 32'h0});
    r = $random(seed);
    wr(UP, r);
    wr(LO, ~r);
    rst_b <= 0;
    repeat (3) @(posedge clk);
    rst_b <= 1;
    @(posedge clk);
    rd(UP, {16'h0, r[15:0]});
    rd(LO, {16'h0, ~r[15:0]});
    x = {r[15:0], ~r[15:0]};
    core_out <= $random(seed);
    core_oe_b <= 32'h0;
    wr(`IDX_HIB_CTRL, 32'h1);
    repeat (6) @(posedge clk);
    check(gpio_oe_b, ~x);
    check(gpio_in_seen, core_out & x);
    check({16'h0, wake_event}, {16'h0, core_out[15:0] & x[15:0]});
    wr(`IDX_HIB_CTRL, 32'h0);
    core_oe_b <= 32'hFFFFFFFF;
    wr(LO, 32'h0);
    wr(UP, 32'h2000);
    wr(`IDX_PIN_IS_INPUT, 32'h800);
    for (int t = 0; t < 4; t++) begin
      ext[11] <= ~t[0];
      wr(`IDX_TRIG_TYPE_HI, t << 6);
      repeat (6) @(posedge clk);
      wr(PND, 32'h800);
      rd(PND, 32'h0);
      ext[11] <= t[0];
      repeat (6) @(posedge clk);
      wr(PND, 32'h0);
      rd(PND, 32'h800);
      check({31'h0, irq}, 32'h0);
      wr(PND, 32'h800);
      rd(PND, {20'h0, t[1], 11'h0});
    end
    wr(`IDX_IRQ_MASK, 32'h800);
    repeat (3) @(posedge clk);
    check({31'h0, irq}, 32'h1);
    wr(`IDX_PIN_IS_INPUT, 32'h0);
    repeat (3) @(posedge clk);
    rd(PND, 32'h0);
    rtc_domain_reset_b <= 0;
    repeat (2) @(posedge clk);
    rtc_domain_reset_b <= 1;
    @(posedge clk);
    rd(UP, 32'h0);
    stop_test;
  end
endmodule
bind gpio_sleep_hold gpio_sleep_hold_assertions u_chk (.clk, .rst_b,
  .rtc_domain_reset_b, .wb_cyc_i, .wb_stb_i, .wb_adr_i, .wb_dat_o, .wb_ack_o,
  .wb_err_o, .core_out, .gpio_out, .gpio_oe_b, .irq);
`default_nettype wire

// ---- test/pin_world.sv ----
// far side of the gpio lines: external drivers set by the bench
// a line the block drives shows its value, a released one the far side's
`default_nettype none
module pin_world (
  input wire logic [31:0] ext_level, // far-side drive
  input wire logic [31:0] gpio_out, // block value
  input wire logic [31:0] gpio_oe_b, // block enable, low drives
  output logic [31:0] pin_level // resolved line
);
  timeunit 1ns;
  timeprecision 1ps;
  assign pin_level = (gpio_out & ~gpio_oe_b)
    | (ext_level & gpio_oe_b);
endmodule
`default_nettype wire
